// ### bench/kwd_watchdog_sva.sv
// port checker for the keyed watchdog
`timescale 1ns/1ps
`default_nettype none
`include "kwd_regs.svh"
module kwd_watchdog_chk
#(
  parameter logic [7:0] KEY_ARM = 8'h3C,
  parameter logic [7:0] KEY_DONE = 8'hC3
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire kwd_pkg::kwd_req_t req_i,
  input wire logic [15:0] system_control_two_i,
  input wire logic [15:0] rd_data_o,
  input wire logic sys_reset_o,
  input wire logic running_o
);
  import kwd_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // decoded writes
  wire logic ctl_wr = req_i.wr && req_i.addr == `KWD_CTRL_ADDR;
  wire logic key_wr = req_i.wr && req_i.addr == `KWD_KEY_ADDR;
  wire logic chk_ok = req_i.wdata[5:3] == `KWD_CHECK_PATTERN;
  wire logic dis_wr = ctl_wr && chk_ok && req_i.wdata[6];
  wire logic permit = system_control_two_i[`KWD_PERMIT_BIT];
  wire logic odd_key = req_i.wdata[7:0] != KEY_ARM
    && req_i.wdata[7:0] != KEY_DONE;
  property p_upper;
    rd_data_o[15:8] == 8'h00;
  endproperty
  a_upper: assert property (p_upper) else $error("upper byte set");
  property p_idle;
    !req_i.rd |=> rd_data_o == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_keyrd;
    req_i.rd && req_i.addr == `KWD_KEY_ADDR |=> rd_data_o == 16'h0000;
  endproperty
  a_keyrd: assert property (p_keyrd) else $error("key read back");
  property p_chk;
    ctl_wr && !chk_ok |=> sys_reset_o;
  endproperty
  a_chk: assert property (p_chk) else $error("check bits ignored");
  property p_key;
    key_wr && odd_key |=> sys_reset_o;
  endproperty
  a_key: assert property (p_key) else $error("bad key ignored");
  property p_sticky;
    sys_reset_o |=> sys_reset_o && !running_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("reset dropped");
  property p_start;
    $fell(rst_i) |=> running_o;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_dis;
    dis_wr && permit |-> ##[1:2] !running_o;
  endproperty
  a_dis: assert property (p_dis) else $error("not disabled");
  property p_nodis;
    running_o && dis_wr && !permit |=> ##1 (running_o || sys_reset_o);
  endproperty
  a_nodis: assert property (p_nodis) else $error("disabled");
  c_rst: cover property ($rose(sys_reset_o));
  c_dis: cover property (dis_wr && permit);
  c_rd: cover property (req_i.rd && req_i.addr == `KWD_COUNT_ADDR);
endmodule
`default_nettype wire

// ### bench/kwd_watchdog_tb.sv
// self-checking bench for the keyed watchdog
`timescale 1ns/1ps
`default_nettype none
`include "kwd_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %0t: %h not %h", $time, g, e); end end
module kwd_watchdog_tb;
  import kwd_pkg::*;
  localparam int BD = 4; // short base divider
  logic core_clk_i;
  logic rst_i;
  kwd_req_t req;
  logic [15:0] sc2;
  logic [15:0] rd_data_o;
  logic sys_reset_o;
  logic running_o;
  logic [15:0] d;
  int bad_count = 0;
  int check_count = 0;
  int n;
  int div_tab [8] = '{1, 1, 2, 4, 8, 16, 32, 64};
  kwd_watchdog #(.BASE_DIV(BD)) kwd_watchdog_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .req_i(req), .system_control_two_i(sc2),
    .rd_data_o(rd_data_o), .sys_reset_o(sys_reset_o),
    .running_o(running_o));
  // 200 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge core_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    #1 v = rd_data_o;
  endtask
  task automatic service();
    wr_reg(`KWD_KEY_ADDR, 16'h003C);
    wr_reg(`KWD_KEY_ADDR, 16'h00C3);
  endtask
  // bounded wait for the reset request, counting cycles
  task automatic wait_rst(input int lim);
    n = 0;
    while (sys_reset_o !== 1'b1 && n < lim)
    begin
      @(posedge core_clk_i);
      #1 n++;
    end
    if (n >= lim)
    begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic t_overflow();
    do_reset();
    @(posedge core_clk_i);
    #1 `CHK(running_o, 1'b1)
    wait_rst(1100);
    `CHK(n >= 256 * BD - 2 && n <= 256 * BD, 1'b1)
  endtask
  task automatic t_regs();
    do_reset();
    `CHK(sys_reset_o, 1'b0)
    rd_reg(`KWD_CTRL_ADDR, d);
    `CHK(d, 16'h0000)
    rd_reg(16'h7020, d);
    `CHK(d, 16'h0000)
    wr_reg(`KWD_CTRL_ADDR, 16'h002F);
    wr_reg(`KWD_KEY_ADDR, 16'hA5C3);
    rd_reg(`KWD_COUNT_ADDR, d);
    `CHK(d, 16'h0001)
    `CHK(sys_reset_o, 1'b0)
    service();
    rd_reg(`KWD_COUNT_ADDR, d);
    `CHK(d, 16'h0000)
  endtask
  task automatic t_prescale();
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(`KWD_CTRL_ADDR, 16'h0028 | 16'(c));
      service();
      repeat (8 * div_tab[c] * BD) @(posedge core_clk_i);
      rd_reg(`KWD_COUNT_ADDR, d);
      `CHK(d >= 16'h0008 && d <= 16'h0009, 1'b1)
    end
  endtask
  task automatic t_disable();
    @(posedge core_clk_i);
    sc2 <= 16'h0000;
    wr_reg(`KWD_CTRL_ADDR, 16'hFF6F);
    rd_reg(`KWD_CTRL_ADDR, d);
    `CHK(d, 16'h0007)
    `CHK(running_o, 1'b1)
    @(posedge core_clk_i);
    sc2 <= 16'h0020;
    wr_reg(`KWD_CTRL_ADDR, 16'h006F);
    rd_reg(`KWD_CTRL_ADDR, d);
    `CHK(d, 16'h0047)
    `CHK(running_o, 1'b0)
    wr_reg(`KWD_CTRL_ADDR, 16'h002F);
    repeat (2) @(posedge core_clk_i);
    #1 `CHK(running_o, 1'b1)
  endtask
  task automatic t_bad_key();
    do_reset();
    wr_reg(`KWD_KEY_ADDR, 16'h0055);
    @(posedge core_clk_i);
    #1 `CHK(sys_reset_o, 1'b1)
    `CHK(running_o, 1'b0)
  endtask
  task automatic t_bad_check();
    do_reset();
    wr_reg(`KWD_CTRL_ADDR, 16'hFF07);
    @(posedge core_clk_i);
    #1 `CHK(sys_reset_o, 1'b1)
    `CHK(running_o, 1'b0)
  endtask
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    sc2 = 16'h0000;
    t_overflow();
    t_regs();
    t_prescale();
    t_disable();
    t_bad_key();
    t_bad_check();
    give_verdict();
  end
endmodule
bind kwd_watchdog kwd_watchdog_chk #(.KEY_ARM(KEY_ARM),
  .KEY_DONE(KEY_DONE)) kwd_watchdog_chk_i (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .req_i(req_i), .system_control_two_i(system_control_two_i),
  .rd_data_o(rd_data_o), .sys_reset_o(sys_reset_o), .running_o(running_o));
`default_nettype wire

// ### hdl/kwd_key_check.sv
// two step service key checker
`timescale 1ns/1ps
`default_nettype none

module kwd_key_check
#(
  parameter logic [7:0] KEY_ARM = 8'h3C,
  parameter logic [7:0] KEY_DONE = 8'hC3
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic key_wr_i,
  input wire logic [7:0] key_i,
  output kwd_pkg::kwd_key_res_t res_o
);
  import kwd_pkg::*;

  // armed after the first key, service on the second
  typedef enum logic {KWD_IDLE, KWD_ARMED} kwd_key_st_t;
  kwd_key_st_t st_q;
  kwd_key_st_t st_d;
  logic is_arm;
  logic is_done;

  assign is_arm = (key_i == KEY_ARM);
  assign is_done = (key_i == KEY_DONE);

  // any byte other than the two keys is a bad key
  logic is_bad;
  assign is_bad = key_wr_i && !is_arm && !is_done;
  // the closing key after the opening key services the counter
  logic is_service;
  assign is_service = key_wr_i && is_done && (st_q == KWD_ARMED);
  // both results leave as one packed word, driven in one place
  assign res_o = '{service: is_service, bad_key: is_bad};

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    if (key_wr_i)
    begin
      case (st_q)
        KWD_IDLE:
          st_d = is_arm ? KWD_ARMED : KWD_IDLE;
        KWD_ARMED:
          st_d = is_arm ? KWD_ARMED : KWD_IDLE;
        default:
          st_d = KWD_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= KWD_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule
`default_nettype wire

// ### hdl/kwd_pkg.sv
// types shared by the keyed watchdog files
package kwd_pkg;

  // one register access from the processor data bus
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } kwd_req_t;

  // what the key checker reports for one key write
  typedef struct packed {
    logic service;
    logic bad_key;
  } kwd_key_res_t;

endpackage

// ### hdl/kwd_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef KWD_REGS_SVH
`define KWD_REGS_SVH

// ****************************************
// register frame
// ****************************************
`define KWD_FRAME_BASE 16'h7020
`define KWD_COUNT_ADDR 16'h7023
`define KWD_KEY_ADDR 16'h7025
`define KWD_CTRL_ADDR 16'h7029

// ****************************************
// control register fields
// ****************************************
`define KWD_CTRL_DIS_BIT 6
`define KWD_CTRL_CHK_HI 5
`define KWD_CTRL_CHK_LO 3
`define KWD_CTRL_PS_HI 2
`define KWD_CTRL_PS_LO 0
`define KWD_CHECK_PATTERN 3'h5
`define KWD_PERMIT_BIT 5

// ****************************************
// reset values
// ****************************************
`define KWD_PS_RESET 3'h0
`define KWD_DIS_RESET 1'b0
`define KWD_COUNT_RESET 8'h00

// ****************************************
// timing counts
// ****************************************
`define KWD_BASE_DIV 512
`define KWD_BASE_W 9
`define KWD_PRE_W 6

`endif

// ### hdl/kwd_tick_gen.sv
// base tick divider and prescaled counter tick
`timescale 1ns/1ps
`default_nettype none
`include "kwd_regs.svh"

module kwd_tick_gen
#(
  parameter int BASE_DIV = `KWD_BASE_DIV
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] prescale_i,
  output logic tick_o
);
  import kwd_pkg::*;

  localparam logic [`KWD_BASE_W-1:0] BASE_LAST =
    `KWD_BASE_W'(BASE_DIV - 1);

  // base divider and prescale counter
  logic [`KWD_BASE_W-1:0] base_q;
  logic [`KWD_PRE_W-1:0] pre_q;
  logic base_tick;
  logic [`KWD_PRE_W-1:0] pre_mask;

  // base tick fires once every BASE_DIV clocks
  assign base_tick = run_i && (base_q == BASE_LAST);

  // codes 0 and 1 both divide by one, code k divides by 2^(k-1)
  assign pre_mask = (prescale_i <= 3'h1) ? '0 :
    `KWD_PRE_W'((7'h01 << (prescale_i - 3'h1)) - 7'h01);

  // counter tick when the selected low prescale bits are all ones
  assign tick_o = base_tick && ((pre_q & pre_mask) == pre_mask);

  // ****************************************
  // dividers, counting from reset release while run_i is high
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      base_q <= '0;
      pre_q <= '0;
    end
    else if (run_i)
    begin
      // base divider wraps at its last count
      base_q <= base_tick ? '0 : base_q + 1'b1;
      if (base_tick)
      begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/kwd_watchdog.sv
// keyed watchdog timer with its byte wide registers
`timescale 1ns/1ps
`default_nettype none
`include "kwd_regs.svh"

module kwd_watchdog
#(
  parameter int BASE_DIV = `KWD_BASE_DIV,
  parameter logic [7:0] KEY_ARM = 8'h3C,
  parameter logic [7:0] KEY_DONE = 8'hC3
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire kwd_pkg::kwd_req_t req_i,
  input wire logic [15:0] system_control_two_i,
  output logic [15:0] rd_data_o,
  output logic sys_reset_o,
  output logic running_o
);
  import kwd_pkg::*;

  // ****************************************
  // register state
  // ****************************************

  // counter of prescaled ticks
  logic [7:0] count_q;
  logic [7:0] count_d;
  // prescale select, fastest after reset
  logic [2:0] prescale_q;
  logic [2:0] prescale_d;
  // watchdog disabled by software
  logic dis_q;
  logic dis_d;
  // sticky system reset request
  logic rst_req_q;
  logic rst_req_d;
  // read data, one cycle after the strobe
  logic [15:0] rd_data_q;
  logic [15:0] rd_data_d;
  // running indication
  logic running_q;

  // ****************************************
  // address decode
  // ****************************************

  // the three registers of the frame
  logic hit_count;
  logic hit_key;
  logic hit_ctrl;
  assign hit_count = (req_i.addr == `KWD_COUNT_ADDR);
  assign hit_key = (req_i.addr == `KWD_KEY_ADDR);
  assign hit_ctrl = (req_i.addr == `KWD_CTRL_ADDR);

  // write strobes per register
  logic wr_key;
  logic wr_ctrl;
  assign wr_key = req_i.wr && hit_key;
  assign wr_ctrl = req_i.wr && hit_ctrl;

  // only the lower byte of a write is taken
  logic [7:0] wbyte;
  assign wbyte = req_i.wdata[7:0];

  // ****************************************
  // control write checks
  // ****************************************

  // check bit field of the written control byte
  logic [2:0] chk_field;
  assign chk_field = wbyte[`KWD_CTRL_CHK_HI:`KWD_CTRL_CHK_LO];

  // wrong check pattern on a control write
  logic bad_check;
  assign bad_check = wr_ctrl && (chk_field != `KWD_CHECK_PATTERN);

  // good control write
  logic good_ctrl;
  assign good_ctrl = wr_ctrl && !bad_check;

  // disable permit flag from system control
  logic permit;
  assign permit = system_control_two_i[`KWD_PERMIT_BIT];

  // disable request honoured only with permit set
  logic dis_req;
  assign dis_req = wbyte[`KWD_CTRL_DIS_BIT];

  // ****************************************
  // key checker and tick generator
  // ****************************************

  // result of a key write
  kwd_key_res_t key_res;

  kwd_key_check
  #(
    .KEY_ARM(KEY_ARM),
    .KEY_DONE(KEY_DONE)
  )
  u_key
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .key_wr_i(wr_key),
    .key_i(wbyte),
    .res_o(key_res)
  );

  // counter tick at the selected rate
  logic tick;
  // the block counts while neither disabled nor requesting reset
  logic run;
  assign run = !dis_q && !rst_req_q;

  kwd_tick_gen
  #(
    .BASE_DIV(BASE_DIV)
  )
  u_tick
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .prescale_i(prescale_q),
    .tick_o(tick)
  );

  // ****************************************
  // reset causes
  // ****************************************

  // counter about to overflow on this tick; a service in the same
  // cycle clears the counter first, so it wins over the overflow
  logic overflow;
  assign overflow = run && tick && !key_res.service &&
    (count_q == 8'hFF);

  // any cause of system reset
  logic reset_cause;
  assign reset_cause = overflow || key_res.bad_key || bad_check;

  // ****************************************
  // next state
  // ****************************************

  // counter: cleared by service, else counts ticks
  always_comb
  begin
    count_d = count_q;
    // a service beats a tick that lands in the same cycle
    if (key_res.service)
    begin
      // a good service clears the counter
      count_d = `KWD_COUNT_RESET;
    end
    else if (run && tick)
    begin
      // count prescaled ticks from reset release
      count_d = count_q + 8'h01;
    end
  end

  // control fields take effect on a good write only
  always_comb
  begin
    prescale_d = prescale_q;
    dis_d = dis_q;
    if (good_ctrl)
    begin
      prescale_d = wbyte[`KWD_CTRL_PS_HI:`KWD_CTRL_PS_LO];
      if (dis_req && permit)
      begin
        // permit set: software may switch off
        dis_d = 1'b1;
      end
      else if (!dis_req)
      begin
        // writing zero turns it back on
        dis_d = 1'b0;
      end
      else
      begin
        // permit clear: disable attempt ignored
        dis_d = dis_q;
      end
    end
  end

  // ****************************************
  // reset request
  // ****************************************

  // reset request stays until the system reset comes back
  assign rst_req_d = rst_req_q || reset_cause;

  // ****************************************
  // read path
  // ****************************************

  // control byte as read back, check bits read zero
  logic [7:0] ctrl_rd;
  assign ctrl_rd = {1'b0, dis_q, 3'h0, prescale_q};

  // read mux, upper byte always zero
  always_comb
  begin
    rd_data_d = 16'h0000;
    if (req_i.rd)
    begin
      if (hit_count)
      begin
        rd_data_d = {8'h00, count_q};
      end
      else if (hit_ctrl)
      begin
        rd_data_d = {8'h00, ctrl_rd};
      end
      else
      begin
        // key register is write only, others unmapped
        rd_data_d = 16'h0000;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************

  // watchdog counter and control
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_q <= `KWD_COUNT_RESET;
      prescale_q <= `KWD_PS_RESET;
      dis_q <= `KWD_DIS_RESET;
    end
    else
    begin
      count_q <= count_d;
      prescale_q <= prescale_d;
      dis_q <= dis_d;
    end
  end

  // reset request and status outputs
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_req_q <= 1'b0;
      running_q <= 1'b0;
    end
    else
    begin
      rst_req_q <= rst_req_d;
      // running follows the next disable and reset request state
      running_q <= !dis_d && !rst_req_d;
    end
  end

  // read data register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_data_q <= 16'h0000;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // every output comes from a flip-flop
  assign rd_data_o = rd_data_q;
  assign sys_reset_o = rst_req_q;
  assign running_o = running_q;

endmodule
`default_nettype wire
